/* rtl/ttx_defs.vh */
// ttx_defs.vh - shared constants of the 10/100 transmit encoder
// assumes: included by bare name into every design file of the encoder
`ifndef TTX_DEFS_VH
`define TTX_DEFS_VH

// ************************************************************
// clock and timing
// ************************************************************
`define TTX_CLK_PERIOD_NS   25
`define TTX_NLP_WIDTH_NS    100
`define TTX_NLP_PERIOD_US   16000
`define TTX_JAB_LIMIT_US    25000
`define TTX_UNJAB_US        500000

// ************************************************************
// 5-bit code-groups
// ************************************************************
`define TTX_CG_IDLE         5'h1F
`define TTX_CG_J            5'h18
`define TTX_CG_K            5'h11
`define TTX_CG_T            5'h0D
`define TTX_CG_R            5'h07
`define TTX_CG_HALT         5'h04

// ************************************************************
// fifo entry layout: {error, gate, nibble}
// ************************************************************
`define TTX_FIFO_WIDTH      6
`define TTX_FIFO_DEPTH      8
`define TTX_FIFO_AW         3
`define TTX_ENT_ERR         5
`define TTX_ENT_GATE        4

// scrambler seed: upper bits fixed, low five from the management address
`define TTX_SEED_HI         6'h2B
`define TTX_BMS_JABBER_BIT  1

`endif

/* rtl/ttx_fifo.v */
// ttx_fifo.v - small synchronous fifo holding MII transmit entries
// assumes: single clock, async active-low reset, drain side may stall
`timescale 1ns/1ps
`include "ttx_defs.vh"

module ttx_fifo #(
	parameter WIDTH = `TTX_FIFO_WIDTH,
	parameter DEPTH = `TTX_FIFO_DEPTH,
	parameter AW    = `TTX_FIFO_AW
) (
	input  wire             clock,
	input  wire             resetn,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	// ************************************************************
	// storage and pointers
	// ************************************************************
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];   // entry storage
	reg [AW-1:0]    wr_ptr_reg;             // next slot to write
	reg [AW-1:0]    rd_ptr_reg;             // oldest entry
	reg [AW:0]      count_reg;              // entries held
	reg             full_reg;               // registered full flag
	reg             empty_reg;              // registered empty flag

	wire push = in_valid & ~full_reg;
	wire pop  = out_ready & ~empty_reg;

	assign in_ready  = ~full_reg;
	assign out_valid = ~empty_reg;
	assign out_data  = mem_reg[rd_ptr_reg];

	// storage write, no reset needed on data
	always @(posedge clock)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	// pointers and flags; simultaneous push and pop keeps the count
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
			full_reg   <= 1'b0;
			empty_reg  <= 1'b1;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push & ~pop)
			begin
				count_reg <= count_reg + 1'b1;
				empty_reg <= 1'b0;
				full_reg  <= (count_reg == DEPTH - 1);
			end
			else if (pop & ~push)
			begin
				count_reg <= count_reg - 1'b1;
				full_reg  <= 1'b0;
				empty_reg <= (count_reg == 1);
			end
		end
	end

endmodule // ttx_fifo

/* rtl/ttx_encoder.v */
// ttx_encoder.v - 10/100 twisted-pair transmit encoder, device side
// assumes: MII entries arrive synchronous to clock with a one-cycle
// send_strobe per send clock rising edge; bit_strobe marks each line
// bit time (half-cell at 10 Mb/s, code bit at 100 Mb/s).
//
// Functional notes
// R1 - 10M: Manchester-encode nibbles while gate high
// R2 - MAC gives valid nibble each send clock
// R3 - frame end: last line transition is positive
// R4 - 10M idle: 100ns link pulse every 16ms
// R5 - jabber cuts transmitter after 20-30ms active
// R6 - output stays off while request asserted
// R7 - re-enable after 400-600ms request deasserted
// R8 - jabber shown as basic status bit one
// R9 - jabber bit zero at 100/1000 Mb/s
// R10 - 100M: nibble converted to 5-bit code-group
// R11 - first preamble byte becomes J then K
// R12 - later preamble and data nibbles encoded
// R13 - gate drop appends T then R
// R14 - idles sent until next frame
// R15 - code-groups shifted out serially
// R16 - sequencing follows standard 100BASE-X transmit machine
// R17 - idle code-group is all ones
// R18 - serial stream XORed with 11-bit scrambler
// R19 - scrambled stream always NRZI encoded
// R20 - error during frame sends halt groups
// R21 - standard data table; three-level line coder
`timescale 1ns/1ps
`include "ttx_defs.vh"

module ttx_encoder #(
	parameter NLP_PERIOD_CYC = `TTX_NLP_PERIOD_US * 1000 / `TTX_CLK_PERIOD_NS,
	parameter JAB_LIMIT_CYC  = `TTX_JAB_LIMIT_US * 1000 / `TTX_CLK_PERIOD_NS,
	parameter UNJAB_CYC      = `TTX_UNJAB_US * 1000 / `TTX_CLK_PERIOD_NS
) (
	input  wire       clock,
	input  wire       resetn,
	input  wire       speed_10,
	input  wire       speed_1000,
	input  wire [4:0] phy_addr,
	input  wire       bit_strobe,
	input  wire       send_strobe,
	input  wire       frame_send_gate,
	input  wire [3:0] send_nibble,
	input  wire       send_error,
	output wire       nibble_ready,
	output reg        line_data,
	output reg        line_enable,
	output reg        code_bit,
	output reg        scram_bit,
	output reg        nrzi_bit,
	output reg        mlt_pos,
	output reg        mlt_neg,
	output reg        basic_mode_status_jabber
);

	// ************************************************************
	// local constants
	// ************************************************************
	localparam [31:0] NLP_WIDTH_CYC =
		(`TTX_NLP_WIDTH_NS + `TTX_CLK_PERIOD_NS - 1) / `TTX_CLK_PERIOD_NS;
	localparam [31:0] NLP_LAST   = NLP_PERIOD_CYC - 1;
	localparam [31:0] JAB_LAST   = JAB_LIMIT_CYC - 1;
	localparam [31:0] UNJAB_LAST = UNJAB_CYC - 1;
	localparam [2:0]  NLP_W_LAST = NLP_WIDTH_CYC[2:0] - 3'h1;

	// 100M group states
	localparam [2:0] G_IDLE = 3'h0;
	localparam [2:0] G_J    = 3'h1;
	localparam [2:0] G_K    = 3'h2;
	localparam [2:0] G_DATA = 3'h3;
	localparam [2:0] G_T    = 3'h4;
	localparam [2:0] G_R    = 3'h5;
	// 10M manchester states
	localparam [1:0] M_IDLE = 2'h0;
	localparam [1:0] M_DATA = 2'h1;
	localparam [1:0] M_TAIL = 2'h2;

	// ************************************************************
	// entry fifo
	// ************************************************************
	wire [5:0] head;        // oldest entry {err, gate, nibble}
	wire       head_valid;  // an entry is waiting
	reg        pop;         // consume the head this cycle

	// the fifo absorbs send clock jitter; nibble_ready stalls the MAC
	ttx_fifo #(
		.WIDTH (`TTX_FIFO_WIDTH),
		.DEPTH (`TTX_FIFO_DEPTH),
		.AW    (`TTX_FIFO_AW)
	) u_fifo (
		.clock     (clock),
		.resetn    (resetn),
		.in_valid  (send_strobe),  // R2
		.in_ready  (nibble_ready),
		.in_data   ({send_error, frame_send_gate, send_nibble}),
		.out_valid (head_valid),
		.out_ready (pop),
		.out_data  (head)
	);

	wire head_gate = head_valid & head[`TTX_ENT_GATE];
	wire head_err  = head[`TTX_ENT_ERR];

	// standard 4B/5B data table
	function [4:0] enc4b5b;
		input [3:0] n;
		begin
			case (n)
				4'h0: enc4b5b = 5'h1E;
				4'h1: enc4b5b = 5'h09;
				4'h2: enc4b5b = 5'h14;
				4'h3: enc4b5b = 5'h15;
				4'h4: enc4b5b = 5'h0A;
				4'h5: enc4b5b = 5'h0B;
				4'h6: enc4b5b = 5'h0E;
				4'h7: enc4b5b = 5'h0F;
				4'h8: enc4b5b = 5'h12;
				4'h9: enc4b5b = 5'h13;
				4'hA: enc4b5b = 5'h16;
				4'hB: enc4b5b = 5'h17;
				4'hC: enc4b5b = 5'h1A;
				4'hD: enc4b5b = 5'h1B;
				4'hE: enc4b5b = 5'h1C;
				default: enc4b5b = 5'h1D;
			endcase
		end
	endfunction

	// ************************************************************
	// state registers
	// ************************************************************
	reg [2:0]  g_state_reg, g_state_next;   // 100M group state
	reg [4:0]  group_reg, group_next;       // group being shifted
	reg [2:0]  gbit_reg, gbit_next;         // bit index in group
	reg [1:0]  m_state_reg, m_state_next;   // 10M state
	reg [3:0]  nib_reg, nib_next;           // nibble being encoded
	reg [2:0]  half_reg, half_next;         // half-cell index 0..7
	reg        level_reg, level_next;       // manchester line level
	// level_reg is shown for the half-cell after its strobe, so the final
	// half-cell and the closing high stand a full half-cell before release
	reg        drive_reg, drive_next;       // line carries a frame half-cell
	reg        req_reg, req_next;           // internal transmit request
	reg        jab_reg;                     // jabber cutoff active
	reg [31:0] jab_cnt_reg;                 // active time counter
	reg [31:0] unjab_cnt_reg;               // quiet time counter
	reg [31:0] nlp_cnt_reg;                 // link pulse period
	reg [2:0]  nlp_w_reg;                   // link pulse width left
	reg        nlp_on_reg;                  // pulse being driven
	reg [10:0] lfsr_reg;                    // scrambler state
	reg        seeded_reg;                  // seed loaded after reset
	reg [1:0]  mlt_ph_reg;                  // three-level phase

	wire m_bit = nib_reg[half_reg[2:1]];    // current data bit, lsb first
	wire fb    = lfsr_reg[10] ^ lfsr_reg[8];

	// ************************************************************
	// next-state logic for both speeds
	// ************************************************************
	always @*
	begin
		g_state_next = g_state_reg;
		group_next   = group_reg;
		gbit_next    = gbit_reg;
		m_state_next = m_state_reg;
		nib_next     = nib_reg;
		half_next    = half_reg;
		level_next   = level_reg;
		req_next     = req_reg;
		drive_next   = drive_reg;
		pop          = 1'b0;
		if (!speed_10)
		begin
			// 100M: pick the next group at each group boundary
			m_state_next = M_IDLE;
			drive_next   = 1'b0;
			if (bit_strobe)
			begin
				if (gbit_reg != 3'h4)
					gbit_next = gbit_reg + 3'h1;  // R15
				else
				begin
					gbit_next = 3'h0;
					case (g_state_reg)
						G_IDLE:
						begin
							pop = head_valid;
							if (head_gate)
							begin
								group_next   = `TTX_CG_J;  // R11
								g_state_next = G_J;
							end
							else
								group_next = `TTX_CG_IDLE;  // R14 R17
						end
						G_J:
						begin
							pop          = head_valid;
							group_next   = `TTX_CG_K;  // R11
							g_state_next = G_K;
						end
						G_K, G_DATA:
						begin
							pop          = head_valid;
							g_state_next = G_DATA;
							if (head_gate)
								// R10 R12 R20 R21
								group_next = head_err ? `TTX_CG_HALT : enc4b5b(head[3:0]);
							else if (head_valid)
							begin
								group_next   = `TTX_CG_T;  // R13
								g_state_next = G_T;
							end
							else
								group_next = `TTX_CG_HALT;  // underrun corrupts frame
						end
						G_T:
						begin
							group_next   = `TTX_CG_R;  // R13
							g_state_next = G_R;
						end
						G_R:
						begin
							group_next   = `TTX_CG_IDLE;  // R14
							g_state_next = G_IDLE;
						end
						default:
						begin
							group_next   = `TTX_CG_IDLE;
							g_state_next = G_IDLE;
						end
					endcase  // R16
				end
			end
		end
		else
		begin
			// 10M: one half-cell per strobe
			g_state_next = G_IDLE;
			if (jab_reg)
			begin
				// R6: discard entries, stay silent while request holds
				m_state_next = M_IDLE;
				drive_next   = 1'b0;
				pop          = head_valid;
				if (head_valid)
					req_next = head[`TTX_ENT_GATE];
			end
			else if (bit_strobe)
			begin
				case (m_state_reg)
					M_IDLE:
					begin
						drive_next = 1'b0;
						pop = head_valid;
						if (head_valid)
							req_next = head[`TTX_ENT_GATE];
						if (head_gate)
						begin
							nib_next     = head[3:0];  // R1
							half_next    = 3'h0;
							m_state_next = M_DATA;
						end
					end
					M_DATA:
					begin
						// first half inverted, second half true: rise at mid for a one
						level_next = half_reg[0] ? m_bit : ~m_bit;  // R1
						drive_next = 1'b1;  // R1
						half_next  = half_reg + 3'h1;
						if (half_reg == 3'h7)
						begin
							pop = head_valid;
							if (head_valid)
								req_next = head[`TTX_ENT_GATE];
							if (head_gate)
								nib_next = head[3:0];
							else if (nib_reg[3])
								m_state_next = M_IDLE;  // R3
							else
								m_state_next = M_TAIL;  // R3
						end
					end
					M_TAIL:
					begin
						level_next   = 1'b1;  // R3
						drive_next   = 1'b1;  // R3
						m_state_next = M_IDLE;
					end
					default:
					begin
						m_state_next = M_IDLE;
						drive_next   = 1'b0;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// encoder state
	// ************************************************************
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			g_state_reg <= G_IDLE;
			group_reg   <= `TTX_CG_IDLE;
			gbit_reg    <= 3'h0;
			m_state_reg <= M_IDLE;
			nib_reg     <= 4'h0;
			half_reg    <= 3'h0;
			level_reg   <= 1'b0;
			drive_reg   <= 1'b0;
			req_reg     <= 1'b0;
		end
		else
		begin
			g_state_reg <= g_state_next;
			group_reg   <= group_next;
			gbit_reg    <= gbit_next;
			m_state_reg <= m_state_next;
			nib_reg     <= nib_next;
			half_reg    <= half_next;
			level_reg   <= level_next;
			drive_reg   <= drive_next;
			req_reg     <= req_next;
		end
	end

	// ************************************************************
	// jabber watch, 10M only
	// ************************************************************
	// counters clear outside 10M so a speed change never leaves a stale cutoff
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			jab_reg       <= 1'b0;
			jab_cnt_reg   <= 32'h0;
			unjab_cnt_reg <= 32'h0;
		end
		else if (!speed_10)
		begin
			jab_reg       <= 1'b0;
			jab_cnt_reg   <= 32'h0;
			unjab_cnt_reg <= 32'h0;
		end
		else if (!jab_reg)
		begin
			unjab_cnt_reg <= 32'h0;
			if (m_state_reg == M_IDLE)
				jab_cnt_reg <= 32'h0;
			else if (jab_cnt_reg == JAB_LAST)
				jab_reg <= 1'b1;  // R5
			else
				jab_cnt_reg <= jab_cnt_reg + 32'h1;
		end
		else
		begin
			jab_cnt_reg <= 32'h0;
			if (req_reg)
				unjab_cnt_reg <= 32'h0;  // R6
			else if (unjab_cnt_reg == UNJAB_LAST)
				jab_reg <= 1'b0;  // R7
			else
				unjab_cnt_reg <= unjab_cnt_reg + 32'h1;
		end
	end

	// ************************************************************
	// link pulse timer, 10M idle only
	// ************************************************************
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			nlp_cnt_reg <= 32'h0;
			nlp_w_reg   <= 3'h0;
			nlp_on_reg  <= 1'b0;
		end
		else if (!speed_10 || m_state_reg != M_IDLE || drive_reg || jab_reg)
		begin
			nlp_cnt_reg <= 32'h0;
			nlp_w_reg   <= 3'h0;
			nlp_on_reg  <= 1'b0;
		end
		else if (nlp_on_reg)
		begin
			nlp_w_reg <= nlp_w_reg - 3'h1;
			if (nlp_w_reg == 3'h0)
				nlp_on_reg <= 1'b0;
		end
		else if (nlp_cnt_reg == NLP_LAST)
		begin
			nlp_cnt_reg <= 32'h0;  // R4
			nlp_w_reg   <= NLP_W_LAST;
			nlp_on_reg  <= 1'b1;
		end
		else
			nlp_cnt_reg <= nlp_cnt_reg + 32'h1;
	end

	// ************************************************************
	// serial path: scramble, NRZI, three-level, line outputs
	// ************************************************************
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			lfsr_reg    <= 11'h7FF;
			seeded_reg  <= 1'b0;
			code_bit    <= 1'b0;
			scram_bit   <= 1'b0;
			nrzi_bit    <= 1'b0;
			mlt_ph_reg  <= 2'h0;
			mlt_pos     <= 1'b0;
			mlt_neg     <= 1'b0;
			line_data   <= 1'b0;
			line_enable <= 1'b0;
			basic_mode_status_jabber <= 1'b0;
		end
		else
		begin
			if (!seeded_reg)
			begin
				// address caught after reset release, never under reset
				lfsr_reg   <= {`TTX_SEED_HI, phy_addr};  // R18
				seeded_reg <= 1'b1;
			end
			// a strobe in the seeding cycle still shifts its code bit out
			if (!speed_10 && bit_strobe)
			begin
				code_bit   <= group_reg[3'h4 - gbit_reg];  // R15
				scram_bit  <= group_reg[3'h4 - gbit_reg] ^ fb;  // R18
				if (seeded_reg)
					lfsr_reg <= {lfsr_reg[9:0], fb};
				if (group_reg[3'h4 - gbit_reg] ^ fb)
				begin
					nrzi_bit   <= ~nrzi_bit;  // R19
					mlt_ph_reg <= mlt_ph_reg + 2'h1;  // R21
					mlt_pos    <= (mlt_ph_reg == 2'h0);
					mlt_neg    <= (mlt_ph_reg == 2'h2);
				end
			end
			if (!speed_10)
			begin
				line_data   <= nrzi_bit;  // R19
				line_enable <= 1'b1;
			end
			else
			begin
				line_data   <= drive_reg ? level_reg : nlp_on_reg;  // R1 R4
				line_enable <= ~jab_reg & (drive_reg | nlp_on_reg);  // R3 R6
			end
			basic_mode_status_jabber <= jab_reg & speed_10 & ~speed_1000;  // R8 R9
		end
	end

endmodule // ttx_encoder

/* dv/ttx_encoder_asserts.sv */
// ttx_encoder_asserts.sv - port checker for the transmit encoder
// assumes: bound onto ttx_encoder, one clock domain
`timescale 1ns/1ps
module ttx_enc_chk #(
	parameter NLP_PERIOD_CYC = 64,
	parameter JAB_LIMIT_CYC  = 200,
	parameter UNJAB_CYC      = 300
) (
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic       speed_10,
	input wire logic       speed_1000,
	input wire logic [4:0] phy_addr,
	input wire logic       bit_strobe,
	input wire logic       send_strobe,
	input wire logic       frame_send_gate,
	input wire logic [3:0] send_nibble,
	input wire logic       send_error,
	input wire logic       nibble_ready,
	input wire logic       line_data,
	input wire logic       line_enable,
	input wire logic       code_bit,
	input wire logic       scram_bit,
	input wire logic       nrzi_bit,
	input wire logic       mlt_pos,
	input wire logic       mlt_neg,
	input wire logic       basic_mode_status_jabber
);
	// ************************************************************
	// properties
	// ************************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// fast mode settled for two samples, so speed changes do not trip checks
	sequence s_fast;
		!speed_10 && !$past(speed_10) && $past(resetn);
	endsequence
	sequence s_jab_rise;
		$rose(basic_mode_status_jabber);
	endsequence
	chk_fast_enable: assert property (s_fast |-> line_enable)
		else $error("driver off in fast mode");
	chk_jab_fast: assert property (s_fast |-> !basic_mode_status_jabber)
		else $error("jabber set in fast mode");
	chk_jab_slow: assert property (basic_mode_status_jabber |-> speed_10)
		else $error("jabber set outside slow mode");
	chk_line_nrzi: assert property (!speed_10 && !$past(speed_10, 2) && $past(resetn, 2)
		|-> line_data == $past(nrzi_bit))
		else $error("line bit does not follow nrzi");
	chk_mlt_excl: assert property (!(mlt_pos && mlt_neg))
		else $error("both mlt levels high");
	chk_mlt_nrzi: assert property (s_fast |-> $changed({mlt_pos, mlt_neg}) == $changed(nrzi_bit))
		else $error("mlt step without nrzi edge");
	chk_code_strobe: assert property (s_fast and $changed(code_bit)
		|-> $past(bit_strobe) || $past(bit_strobe, 2))
		else $error("code bit moved off strobe");
	chk_jab_cut: assert property (s_jab_rise |-> !line_enable)
		else $error("driver on at jabber");
	chk_jab_hold: assert property (basic_mode_status_jabber && $past(basic_mode_status_jabber)
		|-> !line_enable)
		else $error("driver on during jabber");
	chk_jab_giga: assert property (speed_1000 |=> !basic_mode_status_jabber)
		else $error("jabber set in gigabit mode");
	chk_scram_nrzi: assert property (s_fast and $past(bit_strobe)
		|-> $changed(nrzi_bit) == scram_bit)
		else $error("nrzi edge does not follow scrambled bit");
endmodule // ttx_enc_chk

/* dv/ttx_mac_model.sv */
// ttx_mac_model.sv - behavioural MAC feeding MII transmit entries
// assumes: bench queues entries; each is held until nibble_ready is seen
`timescale 1ns/1ps
module ttx_mac_model (
	input  wire logic  clock,
	input  wire logic  resetn,
	input  wire logic  nibble_ready,
	output logic       send_strobe,
	output logic       frame_send_gate,
	output logic [3:0] send_nibble,
	output logic       send_error
);
	// ************************************************************
	// entry queue and push loop
	// ************************************************************
	logic [5:0] q[$];  // {error, gate, nibble} waiting
	int         gap = 0; // idle cycles added to the one that follows each entry, for a slow MAC
	int         k;
	initial
	begin
		send_strobe = 1'b0;
		{send_error, frame_send_gate, send_nibble} = 6'h00;
		forever
		begin
			@(posedge clock);
			if (send_strobe && nibble_ready)
			begin
				void'(q.pop_front());
				#1;
				send_strobe = 1'b0;
				// released lines show garbage, not the last entry
				{send_error, frame_send_gate, send_nibble} = ~{send_error, frame_send_gate, send_nibble};
				for (k = 0; k < gap; k++) @(posedge clock);
			end
			else if (!send_strobe && resetn && q.size() > 0)
			begin
				#1;
				send_strobe = 1'b1;
				{send_error, frame_send_gate, send_nibble} = q[0];
			end
		end
	end
endmodule // ttx_mac_model

/* dv/test_tenhundred_tx_encoder.sv */
// test_tenhundred_tx_encoder.sv - self-checking bench for the encoder
// assumes: shortened timer parameters, mac model on the MII side
`timescale 1ns/1ps
module test_tenhundred_tx_encoder;
	// ************************************************************
	// wiring and clock
	// ************************************************************
	localparam int NLP_P = 64;  // short link pulse period
	localparam int JAB_L = 200; // short jabber limit
	localparam int UNJ   = 300; // short unjab time
	logic       clock, resetn, speed_10, speed_1000, bit_strobe, cap_on;
	logic [1:0] bs_cnt;
	logic [1:0] bs_h = 2'b00;   // strobe history for sampling
	wire        send_strobe, frame_send_gate, send_error, nibble_ready;
	wire [3:0]  send_nibble;
	wire        line_data, line_enable, code_bit, basic_mode_status_jabber;
	logic       cq[$];          // captured line_data at 10M, code_bit at 100M
	logic [4:0] tbl[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	int         err_total = 0;
	int         n_checks = 0;
	ttx_encoder #(.NLP_PERIOD_CYC(NLP_P), .JAB_LIMIT_CYC(JAB_L), .UNJAB_CYC(UNJ)) dut (
		.clock(clock), .resetn(resetn), .speed_10(speed_10), .speed_1000(speed_1000),
		.phy_addr(5'h15), .bit_strobe(bit_strobe), .send_strobe(send_strobe),
		.frame_send_gate(frame_send_gate), .send_nibble(send_nibble),
		.send_error(send_error), .nibble_ready(nibble_ready), .line_data(line_data),
		.line_enable(line_enable), .code_bit(code_bit), .scram_bit(), .nrzi_bit(),
		.mlt_pos(), .mlt_neg(), .basic_mode_status_jabber(basic_mode_status_jabber));
	ttx_mac_model mac (.clock(clock), .resetn(resetn), .nibble_ready(nibble_ready),
		.send_strobe(send_strobe), .frame_send_gate(frame_send_gate),
		.send_nibble(send_nibble), .send_error(send_error));
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// one line bit time every four cycles, so outputs settle before sampling
	initial
	begin
		bit_strobe = 1'b0;
		bs_cnt = 2'd0;
		forever
		begin
			@(posedge clock);
			#1;
			bs_cnt = bs_cnt + 2'd1;
			bit_strobe = (bs_cnt == 2'd0);
		end
	end
	// sample two edges after each strobe
	always @(posedge clock)
	begin
		bs_h <= {bs_h[0], bit_strobe};
		if (bs_h[1] && cap_on && (!speed_10 || line_enable))
			cq.push_back(speed_10 ? line_data : code_bit);
	end
	// ************************************************************
	// helpers
	// ************************************************************
	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task push(input logic g, input logic [3:0] n, input logic e);
		mac.q.push_back({e, g, n});
	endtask
	task wait_q;
		int i;
		for (i = 0; i < 2000 && mac.q.size() > 0; i++) @(posedge clock);
		chk_val(mac.q.size(), 0);
	endtask
	task wait_lvl(input logic v);
		int i;
		for (i = 0; i < 400 && line_enable !== v; i++) @(posedge clock);
		chk_val(line_enable, v);
	endtask
	function automatic logic [9:0] take(int s, int n);
		take = '0;
		for (int k = 0; k < n; k++) take = {take[8:0], cq[s+k]};
	endfunction
	// ************************************************************
	// scenarios
	// ************************************************************
	task t_fast_frame;
		logic [4:0] ex[$];
		int p, i;
		cq.delete();
		cap_on = 1'b1;
		push(1'b1, 4'h5, 1'b0);
		push(1'b1, 4'h5, 1'b0);
		ex = '{5'h18, 5'h11};
		for (i = 0; i < 16; i++)
		begin
			push(1'b1, i[3:0], 1'b0);
			ex.push_back(tbl[i]);
		end
		push(1'b1, 4'h7, 1'b1);
		push(1'b0, 4'h0, 1'b0);
		ex = {ex, 5'h04, 5'h0D, 5'h07, 5'h1F, 5'h1F};
		wait_q();
		repeat (600) @(posedge clock);
		cap_on = 1'b0;
		p = -1;
		for (i = 0; i + 10 <= cq.size(); i++)
			if (p < 0 && take(i, 10) === 10'h311) p = i;
		chk_val(p >= 0, 1);
		for (i = 0; i < ex.size(); i++)
			chk_val(take(p + 5 * i, 5), ex[i]);
	endtask
	task t_manchester;
		logic ex[$];
		logic [7:0] b;
		int i, k, ok, hit;
		@(posedge clock);
		#1 speed_10 = 1'b1;
		repeat (4) @(posedge clock);
		cq.delete();
		cap_on = 1'b1;
		push(1'b1, 4'hA, 1'b0);
		push(1'b1, 4'h3, 1'b0);
		push(1'b0, 4'h0, 1'b0);
		b = 8'h3A;
		for (i = 0; i < 8; i++)
			ex = {ex, !b[i], b[i]};
		ex.push_back(1'b1); // last bit zero: closing high half-cell
		wait_q();
		repeat (200) @(posedge clock);
		cap_on = 1'b0;
		hit = 0;
		for (i = 0; i + 17 <= cq.size(); i++)
		begin
			ok = 1;
			for (k = 0; k < 17; k++)
				if (cq[i+k] !== ex[k]) ok = 0;
			if (ok) hit = 1;
		end
		chk_val(hit, 1);
	endtask
	task t_link_pulse;
		int w, g;
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		for (w = 0; w < 50 && line_enable === 1'b1; w++)
		begin
			chk_val(line_data, 1);
			@(posedge clock);
		end
		chk_val(w == 4 || w == 5, 1);
		for (g = w; g < 400 && line_enable !== 1'b1; g++) @(posedge clock);
		chk_val(g >= NLP_P && g <= NLP_P + 6, 1);
	endtask
	task t_jabber;
		int i;
		mac.gap = 1;
		for (i = 0; i < 14; i++) push(1'b1, i[3:0], 1'b0);
		for (i = 0; i < 700 && basic_mode_status_jabber !== 1'b1; i++) @(posedge clock);
		chk_val(basic_mode_status_jabber, 1);
		chk_val(i > JAB_L, 1);
		chk_val(line_enable, 0);
		#1 speed_1000 = 1'b1;
		repeat (2) @(posedge clock);
		chk_val(basic_mode_status_jabber, 0);
		#1 speed_1000 = 1'b0;
		wait_q();
		push(1'b0, 4'h0, 1'b0);
		wait_q();
		repeat (UNJ / 2) @(posedge clock);
		chk_val(basic_mode_status_jabber, 1);
		for (i = 0; i < 700 && basic_mode_status_jabber !== 1'b0; i++) @(posedge clock);
		chk_val(basic_mode_status_jabber, 0);
		mac.gap = 0;
	endtask
	// ************************************************************
	// sequence, watchdog and verdict
	// ************************************************************
	task finish_test;
		if (err_total == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		resetn = 1'b0;
		speed_10 = 1'b0;
		speed_1000 = 1'b0;
		cap_on = 1'b0;
		repeat (5) @(posedge clock);
		#1 resetn = 1'b1;
		t_fast_frame();
		t_manchester();
		t_link_pulse();
		t_jabber();
		finish_test();
	end
	initial
	begin
		repeat (20000) @(posedge clock);
		err_total++;
		finish_test();
	end
endmodule // test_tenhundred_tx_encoder
bind ttx_encoder ttx_enc_chk #(.NLP_PERIOD_CYC(NLP_PERIOD_CYC),
	.JAB_LIMIT_CYC(JAB_LIMIT_CYC), .UNJAB_CYC(UNJAB_CYC)) u_chk (
	.clock(clock), .resetn(resetn), .speed_10(speed_10), .speed_1000(speed_1000),
	.phy_addr(phy_addr), .bit_strobe(bit_strobe), .send_strobe(send_strobe),
	.frame_send_gate(frame_send_gate), .send_nibble(send_nibble),
	.send_error(send_error), .nibble_ready(nibble_ready), .line_data(line_data),
	.line_enable(line_enable), .code_bit(code_bit), .scram_bit(scram_bit),
	.nrzi_bit(nrzi_bit), .mlt_pos(mlt_pos), .mlt_neg(mlt_neg),
	.basic_mode_status_jabber(basic_mode_status_jabber));
